//--- sepwg_fifo.sv
`default_nettype none
module sepwg_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Filling and draining sides
  sepwg_stream_if.sink wr,
  sepwg_stream_if.source rd
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least 2");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wptr;
  logic [AW:0] rptr;

  // Extra pointer bit tells full from empty
  wire ptr_lo_eq = wptr[AW-1:0] == rptr[AW-1:0];
  wire full = ptr_lo_eq && (wptr[AW] != rptr[AW]);
  wire empty = wptr == rptr;
  wire push = wr.valid && !full;
  wire pop = rd.valid && rd.ready;

  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data = mem[rptr[AW-1:0]];

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (push) begin
        wptr <= wptr + 1'b1;
      end
      if (pop) begin
        rptr <= rptr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wptr[AW-1:0]] <= wr.data;
    end
  end
endmodule
`default_nettype wire

//--- sepwg_host.sv
`default_nettype none
// ****************************************
// Link host: mode 0, clock still between frames
// ****************************************
module sepwg_host (
  // Serial link pins
  output logic sck_o,
  output logic cs_n_o,
  output logic mosi_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // Bits go MSB first; nbits below a whole byte count leaves a partial tail
  task automatic frame(input logic [7:0] q[$], input int nbits);
    #2.7 cs_n_o = 1'b0;
    #7;
    for (int i = 0; i < nbits; i++) begin
      mosi_o = q[i / 8][7 - (i % 8)];
      #6 sck_o = 1'b1;
      #6 sck_o = 1'b0;
    end
    // Up before the next rising edge; the data line stops showing its last bit
    #3 cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #20;
  endtask
endmodule
`default_nettype wire

//--- sepwg_pkg.sv
// How it works
// - A write frame is the write opcode, a 16-bit address sent MSB first, then one or more data bytes back to back.
// - One write frame changes at most 32 bytes, all inside a single page.
// - Pages are 32-byte aligned: low five address bits run from 00000 to 11111.
// - After the last byte of a page the in-page pointer wraps to the page start; only the low five bits advance.
// - With more than 32 data bytes only the final 32 survive, later bytes overwriting earlier ones.
// - Locations inside the guarded region are never changed, whatever the latch, arm bit or protect pin say.
// - Locations outside the guarded region change only when the write latch is 1.
// - When an internal write cycle completes the write latch is cleared.
// - Hardware protection plays no part in array writes.
// - A status update of arm and guard bits is taken only with the latch at 1 and hardware protection off (arm 0 or pin high).
// - Only address bits 12 to 0 select a location; bits 15 to 13 are ignored.
// - The write opcode is 0000 X010 with the X bit ignored.
// - Guard 00 protects nothing, 01 protects 1800h-1FFFh, 10 protects 1000h-1FFFh, 11 protects everything.
// - While a write cycle runs the device reports busy and ignores every opcode but status read.
`default_nettype none
package sepwg_pkg;
  localparam int CLK_MHZ = 250;
  localparam int WRITE_CYCLE_MS = 5;
  localparam int WRITE_CYCLES = WRITE_CYCLE_MS * 1000 * CLK_MHZ;
  localparam int FIFO_DEPTH = 8;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 13;
  localparam int SLOT_W = 5;
  localparam int PAGE_W = ADDR_W - SLOT_W;
  localparam int PAGE_BYTES = 32;
  localparam logic [7:0] OP_MASK = 8'hF7;
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_SET_LATCH = 8'h06;
  localparam logic [7:0] OP_CLR_LATCH = 8'h04;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_UPDATE = 8'h01;
  localparam logic [12:0] GUARD_QUARTER = 13'h1800;
  localparam logic [12:0] GUARD_HALF = 13'h1000;
  localparam logic [12:0] GUARD_ALL = 13'h0000;
  localparam logic [1:0] GUARD_NONE = 2'h0;
  localparam logic [1:0] GUARD_Q = 2'h1;
  localparam logic [1:0] GUARD_H = 2'h2;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_LATCH_BIT = 1;
  localparam int ST_GLO_BIT = 2;
  localparam int ST_GHI_BIT = 3;
  localparam int ST_ARM_BIT = 7;
  localparam logic [7:0] STATUS_BUSY_VALUE = 8'hFF;
  localparam logic LATCH_RST = 1'b0;
  localparam logic ARM_RST = 1'b0;
  localparam logic [1:0] GUARD_RST = 2'h0;
  localparam logic [1:0] IDX_OP = 2'h0;
  localparam logic [1:0] IDX_AHI = 2'h1;
  localparam logic [1:0] IDX_ALO = 2'h2;
  localparam logic [1:0] IDX_DATA = 2'h3;
  typedef enum logic [1:0] {SEPWG_IDLE, SEPWG_COMMIT, SEPWG_WAIT} sepwg_state_t;
endpackage
`default_nettype wire

//--- sepwg_stream_if.sv
`default_nettype none
interface sepwg_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport sink (input valid, input data, output ready);
  modport source (output valid, output data, input ready);
endinterface
`default_nettype wire

//--- sepwg_top.sv
`default_nettype none
module sepwg_top #(
  parameter int WRITE_CYCLES = sepwg_pkg::WRITE_CYCLES,
  parameter int FIFO_DEPTH = sepwg_pkg::FIFO_DEPTH
) (
  // Core clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Serial link pins
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  input wire logic wp_n_i,
  // Array write port
  output logic mem_we_o,
  output logic [sepwg_pkg::ADDR_W-1:0] mem_addr_o,
  output logic [sepwg_pkg::BYTE_W-1:0] mem_wdata_o,
  // Status
  output logic busy_o,
  output logic [7:0] status_o
);
  localparam int AW = sepwg_pkg::ADDR_W;
  localparam int SW = sepwg_pkg::SLOT_W;
  localparam int PW = sepwg_pkg::PAGE_W;
  localparam int NB = sepwg_pkg::PAGE_BYTES;

  if (WRITE_CYCLES < 1 || FIFO_DEPTH < 2) begin : g_bad_param
    $error("write cycle count and fifo depth out of range");
  end

  // ************************************************************
  // Link domain
  // ************************************************************
  logic [2:0] lnk_bit;
  logic [6:0] lnk_shift;
  logic [7:0] lnk_byte;
  logic lnk_tog;

  // Chip select clears the bit count, so a partial byte dies here
  always_ff @(posedge sck_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      lnk_bit <= 3'h0;
      lnk_shift <= 7'h00;
    end else begin
      lnk_bit <= lnk_bit + 3'h1;
      lnk_shift <= {lnk_shift[5:0], mosi_i};
    end
  end

  wire lnk_last = lnk_bit == 3'h7;

  // Byte held stable for eight link clocks, far longer than the sync
  always_ff @(posedge sck_i or posedge srst_i) begin
    if (srst_i) begin
      lnk_byte <= 8'h00;
      lnk_tog <= 1'b0;
    end else if (lnk_last) begin
      lnk_byte <= {lnk_shift, mosi_i};
      lnk_tog <= ~lnk_tog;
    end
  end

  // ************************************************************
  // Crossing into the core domain
  // ************************************************************
  logic tog_s1, tog_s2, tog_s3;
  logic cs_s1, cs_s2, cs_s3;
  logic wp_s1, wp_s2;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      wp_s1 <= 1'b1;
      wp_s2 <= 1'b1;
    end else begin
      tog_s1 <= lnk_tog;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
      cs_s1 <= cs_n_i;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      wp_s1 <= wp_n_i;
      wp_s2 <= wp_s1;
    end
  end

  wire byte_ev = tog_s2 ^ tog_s3;
  wire end_ev = cs_s2 && !cs_s3;

  sepwg_stream_if #(.W(sepwg_pkg::BYTE_W)) fin ();
  sepwg_stream_if #(.W(sepwg_pkg::BYTE_W)) fout ();

  logic cap_v;
  logic [7:0] cap_d;

  // A new byte wins over the hand-off of the old one
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cap_v <= 1'b0;
      cap_d <= 8'h00;
    end else if (byte_ev) begin
      cap_v <= 1'b1;
      cap_d <= lnk_byte;
    end else if (fin.ready) begin
      cap_v <= 1'b0;
    end
  end

  assign fin.valid = cap_v;
  assign fin.data = cap_d;

  sepwg_fifo #(
    .W(sepwg_pkg::BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(core_clk_i),
    .srst_i(srst_i),
    .wr(fin),
    .rd(fout)
  );

  // ************************************************************
  // Frame parser
  // ************************************************************
  sepwg_pkg::sepwg_state_t state, next_state;
  logic [1:0] idx;
  logic [7:0] op;
  logic [4:0] ahi;
  logic [PW-1:0] page;
  logic [SW-1:0] ptr;
  logic data_seen;
  logic sr_seen;
  logic [7:0] sr_byte;
  logic end_pend;
  logic latch;
  logic arm;
  logic [1:0] guard;
  logic [7:0] sr_hold;
  logic sr_apply;
  logic [SW-1:0] cptr;
  logic [31:0] cyc_cnt;
  logic slot_set [NB];
  logic [7:0] page_buf [NB];

  wire st_idle = state == sepwg_pkg::SEPWG_IDLE;
  wire st_commit = state == sepwg_pkg::SEPWG_COMMIT;
  wire st_wait = state == sepwg_pkg::SEPWG_WAIT;

  // Parser stalls only while the page buffer is being committed
  assign fout.ready = !st_commit;
  wire pop = fout.valid && fout.ready;

  wire [7:0] op_m = op & sepwg_pkg::OP_MASK;
  wire is_write = op_m == sepwg_pkg::OP_WRITE;
  wire is_set = op_m == sepwg_pkg::OP_SET_LATCH;
  wire is_clr = op_m == sepwg_pkg::OP_CLR_LATCH;
  wire is_sr = op_m == sepwg_pkg::OP_STATUS_UPDATE;
  wire op_got = idx != sepwg_pkg::IDX_OP;
  wire wr_pop = pop && idx == sepwg_pkg::IDX_DATA && is_write;

  wire drained = !cap_v && !fout.valid && !byte_ev;
  wire end_take = end_pend && drained && !st_commit;
  wire act = end_take && st_idle;
  wire hw_prot = arm && !wp_s2;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      end_pend <= 1'b0;
    end else if (end_ev) begin
      end_pend <= 1'b1;
    end else if (end_take) begin
      end_pend <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      idx <= sepwg_pkg::IDX_OP;
      op <= 8'h00;
      data_seen <= 1'b0;
      sr_seen <= 1'b0;
      sr_byte <= 8'h00;
    end else if (end_take) begin
      idx <= sepwg_pkg::IDX_OP;
    end else if (pop) begin
      if (idx != sepwg_pkg::IDX_DATA) begin
        idx <= idx + 2'h1;
      end
      if (idx == sepwg_pkg::IDX_OP) begin
        op <= fout.data;
        data_seen <= 1'b0;
        sr_seen <= 1'b0;
      end
      if (idx == sepwg_pkg::IDX_AHI && is_sr) begin
        sr_seen <= 1'b1;
        sr_byte <= fout.data;
      end
      if (wr_pop) begin
        data_seen <= 1'b1;
      end
    end
  end

  // Address: top three bits of the high byte are dropped
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ahi <= 5'h00;
      page <= '0;
      ptr <= '0;
    end else if (pop && idx == sepwg_pkg::IDX_AHI) begin
      ahi <= fout.data[4:0];
    end else if (pop && idx == sepwg_pkg::IDX_ALO) begin
      page <= {ahi, fout.data[7:5]};
      ptr <= fout.data[4:0];
    end else if (wr_pop) begin
      ptr <= ptr + 5'h01;
    end
  end

  // ************************************************************
  // Page buffer
  // ************************************************************
  for (genvar i = 0; i < NB; i++) begin : g_slot
    always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
        slot_set[i] <= 1'b0;
        page_buf[i] <= 8'h00;
      end else if (pop && idx == sepwg_pkg::IDX_OP) begin
        slot_set[i] <= 1'b0;
      end else if (wr_pop && ptr == SW'(i)) begin
        slot_set[i] <= 1'b1;
        page_buf[i] <= fout.data;
      end
    end
  end

  // ************************************************************
  // Guard decode
  // ************************************************************
  wire [AW-1:0] guard_base =
    (guard == sepwg_pkg::GUARD_Q) ? sepwg_pkg::GUARD_QUARTER :
    (guard == sepwg_pkg::GUARD_H) ? sepwg_pkg::GUARD_HALF :
    sepwg_pkg::GUARD_ALL;
  wire guard_on = guard != sepwg_pkg::GUARD_NONE;
  wire [AW-1:0] c_addr = {page, cptr};
  wire c_guarded = guard_on && (c_addr >= guard_base);
  wire c_hit = st_commit && slot_set[cptr] && !c_guarded;
  wire o_guarded = guard_on && (mem_addr_o >= guard_base);

  // ************************************************************
  // Write cycle control
  // ************************************************************
  // Hardware protection is deliberately absent from this term
  // Frame with no whole opcode must not replay the previous command
  wire start_write = act && op_got && is_write && data_seen &&
    latch;
  wire start_sr = act && op_got && is_sr && sr_seen && latch &&
    !hw_prot;
  wire cyc_done = st_wait && cyc_cnt == 32'(WRITE_CYCLES - 1);
  wire commit_end = st_commit && cptr == '1;

  always_comb begin
    next_state = state;
    case (state)
      sepwg_pkg::SEPWG_IDLE: begin
        if (start_write) begin
          next_state = sepwg_pkg::SEPWG_COMMIT;
        end else if (start_sr) begin
          next_state = sepwg_pkg::SEPWG_WAIT;
        end
      end
      sepwg_pkg::SEPWG_COMMIT: begin
        if (commit_end) begin
          next_state = sepwg_pkg::SEPWG_WAIT;
        end
      end
      sepwg_pkg::SEPWG_WAIT: begin
        if (cyc_done) begin
          next_state = sepwg_pkg::SEPWG_IDLE;
        end
      end
      default: begin
        next_state = sepwg_pkg::SEPWG_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state <= sepwg_pkg::SEPWG_IDLE;
      cptr <= '0;
      cyc_cnt <= 32'h0000_0000;
    end else begin
      state <= next_state;
      cptr <= st_commit ? cptr + 5'h01 : 5'h00;
      cyc_cnt <= st_wait ? cyc_cnt + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  // Latch: completion clear first, then commands of an idle frame
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      latch <= sepwg_pkg::LATCH_RST;
    end else if (cyc_done) begin
      latch <= 1'b0;
    end else if (act && op_got && is_set) begin
      latch <= 1'b1;
    end else if (act && op_got && is_clr) begin
      latch <= 1'b0;
    end
  end

  // New guard bits take effect only when the cycle completes
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      arm <= sepwg_pkg::ARM_RST;
      guard <= sepwg_pkg::GUARD_RST;
      sr_hold <= 8'h00;
      sr_apply <= 1'b0;
    end else if (start_sr) begin
      sr_hold <= sr_byte;
      sr_apply <= 1'b1;
    end else if (cyc_done) begin
      sr_apply <= 1'b0;
      if (sr_apply) begin
        arm <= sr_hold[sepwg_pkg::ST_ARM_BIT];
        guard <= {sr_hold[sepwg_pkg::ST_GHI_BIT],
                  sr_hold[sepwg_pkg::ST_GLO_BIT]};
      end
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  logic [7:0] stat_word;

  always_comb begin
    stat_word = 8'h00;
    stat_word[sepwg_pkg::ST_ARM_BIT] = arm;
    stat_word[sepwg_pkg::ST_GHI_BIT] = guard[1];
    stat_word[sepwg_pkg::ST_GLO_BIT] = guard[0];
    stat_word[sepwg_pkg::ST_LATCH_BIT] = latch;
  end

  wire next_busy = next_state != sepwg_pkg::SEPWG_IDLE;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      mem_we_o <= 1'b0;
      mem_addr_o <= '0;
      mem_wdata_o <= 8'h00;
      busy_o <= 1'b0;
      status_o <= 8'h00;
    end else begin
      mem_we_o <= c_hit;
      mem_addr_o <= c_addr;
      mem_wdata_o <= page_buf[cptr];
      busy_o <= next_busy;
      status_o <= next_busy ? sepwg_pkg::STATUS_BUSY_VALUE : stat_word;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);

  chk_latch_cleared_end: assert property (cyc_done |=> !latch)
    else $error("latch still set after write cycle");
  chk_guard_never_hit: assert property (mem_we_o |-> !o_guarded)
    else $error("write into guarded region");
  chk_commit_needs_latch: assert property (
    $rose(st_commit) |-> $past(latch))
    else $error("commit started without latch");
  chk_commit_length: assert property (
    $rose(st_commit) |-> ##31 st_commit ##1 st_wait)
    else $error("commit not 32 slots long");
  chk_one_page: assert property (
    mem_we_o |-> mem_addr_o[AW-1:SW] == page)
    else $error("write left the page");
  chk_slot_wrap: assert property (
    (wr_pop && ptr == 5'h1F) |=> ptr == 5'h00)
    else $error("pointer did not wrap in page");
  chk_status_gate: assert property (
    $rose(sr_apply) |-> $past(latch && !hw_prot))
    else $error("status update accepted while locked");
  chk_busy_ignores: assert property (
    (end_take && st_wait && !cyc_done) |=> $stable(latch) && st_wait)
    else $error("command acted on while busy");
  chk_set_latch_op: assert property (
    (act && op_got && is_set) |=> latch)
    else $error("set latch command not taken");

  cov_commit: cover property ($rose(st_commit));
  cov_wrap: cover property (wr_pop && ptr == 5'h1F);
  cov_status_update: cover property ($fell(sr_apply) && st_idle);
  cov_fifo_full: cover property (cap_v && !fin.ready);
endmodule
`default_nettype wire

//--- tb.sv
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
  n_mismatch++; $display("ERROR %s exp %0h got %0h", nm, ex, got); end end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Clocks, pins and memory image
  // ****************************************
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic wp_n_i = 1'b1;
  wire logic sck;
  wire logic cs_n;
  wire logic mosi;
  logic mem_we_o;
  logic [12:0] mem_addr_o;
  logic [7:0] mem_wdata_o;
  logic busy_o;
  logic [7:0] status_o;
  logic [7:0] mem [8192];
  logic [7:0] exp_mem [8192];
  logic [1:0] guard = 2'h0;
  logic arm = 1'b0;
  int n_mismatch = 0;
  int n_tests = 0;
  initial forever #2 core_clk_i = ~core_clk_i;
  sepwg_host u_host (.sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi));
  // Short write cycle keeps the run brief
  sepwg_top #(.WRITE_CYCLES(20), .FIFO_DEPTH(8)) u_dut (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .sck_i(sck),
    .cs_n_i(cs_n), .mosi_i(mosi), .wp_n_i(wp_n_i),
    .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .busy_o(busy_o), .status_o(status_o));
  always @(posedge core_clk_i) begin
    if (mem_we_o === 1'b1) mem[mem_addr_o] <= mem_wdata_o;
  end
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  // Bounded wait for the write cycle to end
  task automatic idle;
    int k;
    k = 0;
    cyc(12);
    while (busy_o !== 1'b0 && k < 400) begin
      cyc(1);
      k++;
    end
    if (k >= 400) begin
      n_mismatch++;
      finish_test();
    end
    cyc(2);
  endtask
  task automatic op(input logic [7:0] c);
    u_host.frame({c}, 8);
    idle();
  endtask
  function automatic logic guarded(input logic [12:0] a);
    case (guard)
      2'h0: return 1'b0;
      2'h1: return a >= 13'h1800;
      2'h2: return a >= 13'h1000;
      default: return 1'b1;
    endcase
  endfunction
  task automatic chk_mem;
    for (int i = 0; i < 8192; i++) `CHK("mem", exp_mem[i], mem[i])
  endtask
  // Latch, then page write; late sends a latch command while busy
  task automatic wr(input logic [15:0] a, input int n, input logic [7:0] b0,
                    input logic [7:0] opc, input logic late);
    logic [7:0] q[$];
    logic [12:0] x;
    op(8'h06);
    q = {opc, a[15:8], a[7:0]};
    for (int i = 0; i < n; i++) begin
      q.push_back(8'(b0 + i));
      x = {a[12:5], 5'(a[4:0] + i)};
      if (!guarded(x)) exp_mem[x] = 8'(b0 + i);
    end
    u_host.frame(q, q.size() * 8);
    if (late) u_host.frame({8'h06}, 8);
    cyc(12);
    `CHK("busy", 1'b1, busy_o)
    `CHK("status busy", 8'hFF, status_o)
    idle();
    `CHK("latch", 1'b0, status_o[1])
  endtask
  // Status update; take says whether it is expected to land
  task automatic sr(input logic [7:0] d, input logic take);
    op(8'h06);
    u_host.frame({8'h01, d}, 16);
    idle();
    if (take) begin
      arm = d[7];
      guard = {d[3], d[2]};
    end
    `CHK("status", {arm, 3'h0, guard, ~take, 1'b0}, status_o)
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    #300us;
    n_mismatch++;
    finish_test();
  end
  initial begin
    for (int i = 0; i < 8192; i++) begin
      mem[i] = 8'h00;
      exp_mem[i] = 8'h00;
    end
    cyc(16);
    srst_i = 1'b0;
    cyc(2);
    `CHK("status reset", 8'h00, status_o)
    `CHK("busy reset", 1'b0, busy_o)
    // Write with the latch clear runs no cycle
    u_host.frame({8'h02, 8'h00, 8'h40, 8'h11}, 32);
    cyc(4);
    `CHK("busy no latch", 1'b0, busy_o)
    idle();
    op(8'h06);
    `CHK("latch set", 8'h02, status_o)
    op(8'h04);
    `CHK("latch clear", 8'h00, status_o)
    // Start two slots before page end, 34 bytes, top address bits set
    wr(16'hE03E, 34, 8'h20, 8'h02, 1'b0);
    wr(16'h0105, 1, 8'h5A, 8'h0A, 1'b0);
    for (int g = 1; g < 4; g++) begin
      sr({4'h0, 2'(g), 2'h0}, 1'b1);
      wr(16'h0FFF, 1, 8'(8'h30 + g), 8'h02, 1'b0);
      wr(16'h17FF, 1, 8'(8'h40 + g), 8'h02, 1'b0);
      wr(16'h1FFF, 1, 8'(8'h50 + g), 8'h02, 1'b0);
    end
    chk_mem();
    sr(8'h80, 1'b1);
    wp_n_i = 1'b0;
    sr(8'h04, 1'b0);
    // Empty frame after a refused update must not apply the old byte
    wp_n_i = 1'b1;
    cyc(4);
    u_host.frame({8'h00}, 0);
    idle();
    `CHK("empty frame", 8'h82, status_o)
    wp_n_i = 1'b0;
    cyc(4);
    wr(16'h1234, 2, 8'h66, 8'h02, 1'b0);
    wp_n_i = 1'b1;
    sr(8'h00, 1'b1);
    // Frame ends with four bits of a data byte
    op(8'h06);
    u_host.frame({8'h02, 8'h00, 8'h40, 8'h77}, 28);
    cyc(4);
    `CHK("busy partial", 1'b0, busy_o)
    idle();
    `CHK("latch partial", 8'h02, status_o)
    op(8'h04);
    wr(16'h0300, 3, 8'h90, 8'h02, 1'b1);
    chk_mem();
    finish_test();
  end
endmodule
`default_nettype wire
